// >>> hdl/ocd_decoder.sv
// Fundamental command decoder with busy flag, address counter and internal RAMs
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "ocd_params.svh"

module ocd_decoder (
    input  wire logic               sys_clk_i,
    input  wire logic               resetn_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    input  wire logic               dc_i,
    input  wire logic [7:0]         data_i,
    input  wire logic               entry_incr_i,
    output logic [7:0]              data_o,
    output ocd_pkg::ocd_cfg_s       cfg_o,
    output ocd_pkg::ocd_shift_s     shift_o,
    output logic [6:0]              addr_counter_o,
    output logic                    cgram_target_o,
    output logic                    scroll_invalid_o
);

    // ==========================================
    // State
    ocd_pkg::ocd_cfg_s cfg;
    logic              alt_table_select;
    logic              ext_select;
    logic              oled_set_select;
    logic [1:0]        height_format;
    logic              shift_vs_scroll_mode;
    logic [3:0]        line_shift_enable;
    logic [3:0]        line_scroll_enable;
    logic              line_count_sel;
    logic              wide_line_mode;
    logic              double_height_two_line;
    logic              cgram_blink_on;
    logic              invert_all;
    logic [5:0]        scroll_amount;
    logic [6:0]        addr_counter;
    logic              cgram_target;
    logic              busy_flag;
    logic [2:0]        busy_cnt;
    logic              status_second;
    logic [7:0]        ddram [0:`OCD_DDRAM_WORDS-1];
    logic [7:0]        cgram [0:`OCD_CGRAM_WORDS-1];

    logic fund_tbl;
    logic cmd_wr;
    logic data_acc;
    logic [6:0] next_addr;
    logic       is_shift_cmd;
    logic       is_func_set;
    logic       is_ext_func;
    logic       is_addr_cmd;
    logic       sel_ext;
    logic       sel_alt;
    logic       line_wr_shift;
    logic       line_wr_scroll;

    localparam logic [3:0] LINE_EN_RST = `OCD_LINE_EN_RST;

    assign cfg = '{alt_table_select:       alt_table_select,
                   ext_select:             ext_select,
                   oled_set_select:        oled_set_select,
                   height_format:          height_format,
                   shift_vs_scroll_mode:   shift_vs_scroll_mode,
                   line_shift_enable:      line_shift_enable,
                   line_scroll_enable:     line_scroll_enable,
                   line_count_sel:         line_count_sel,
                   wide_line_mode:         wide_line_mode,
                   double_height_two_line: double_height_two_line,
                   cgram_blink_on:         cgram_blink_on,
                   invert_all:             invert_all,
                   scroll_amount:          scroll_amount};

    // ==========================================
    // Command classes
    assign is_shift_cmd   = data_i[7:4] == 4'h1;
    assign is_func_set    = data_i[7:5] == 3'h1;
    // Extended function set shares 0x08/0x09, bit0 is the wide-line flag
    assign is_ext_func    = data_i[7:1] == 7'h04;
    assign is_addr_cmd    = data_i[7];
    assign sel_ext        = ext_select && !alt_table_select;
    assign sel_alt        = ext_select && alt_table_select;
    assign line_wr_shift  = cmd_wr && is_shift_cmd && sel_alt && shift_vs_scroll_mode;
    assign line_wr_scroll = cmd_wr && is_shift_cmd && sel_alt && !shift_vs_scroll_mode;

    assign fund_tbl = !cfg.oled_set_select;
    assign cmd_wr   = wr_i && !dc_i && fund_tbl;
    assign data_acc = (wr_i || rd_i) && dc_i && fund_tbl;
    assign next_addr = entry_incr_i ? addr_counter + 7'h01 : addr_counter - 7'h01;

    // ==========================================
    // Table select bits
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            alt_table_select <= 1'b0;
            ext_select       <= 1'b0;
        end else if (cmd_wr && is_func_set) begin
            ext_select <= data_i[1];
            if (!data_i[1]) begin
                alt_table_select <= data_i[0];
            end
        end
    end

    // Only the extended table can raise it, and nothing in this project does, so it holds its reset value 0
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            oled_set_select <= 1'b0;
        end
    end

    // ==========================================
    // Double-height format and shift/scroll mode
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            height_format        <= `OCD_HEIGHT_FMT_RST;
            shift_vs_scroll_mode <= 1'b0;
        end else if (cmd_wr && is_shift_cmd && sel_ext) begin
            height_format        <= data_i[3:2];
            shift_vs_scroll_mode <= data_i[0];
        end
    end

    // ==========================================
    // Per-line shift and scroll enables
    for (genvar ln = 0; ln < 4; ln++) begin : g_line
        always_ff @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                line_shift_enable[ln] <= LINE_EN_RST[ln];
            end else if (line_wr_shift) begin
                line_shift_enable[ln] <= data_i[ln];
            end
        end

        always_ff @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                line_scroll_enable[ln] <= LINE_EN_RST[ln];
            end else if (line_wr_scroll) begin
                line_scroll_enable[ln] <= data_i[ln];
            end
        end
    end

    // ==========================================
    // Function set fields
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            line_count_sel         <= 1'b0;
            double_height_two_line <= 1'b0;
            cgram_blink_on         <= 1'b0;
            invert_all             <= 1'b0;
        end else if (cmd_wr && is_func_set) begin
            line_count_sel <= data_i[3];
            if (!data_i[1]) begin
                double_height_two_line <= data_i[2];
            end else begin
                cgram_blink_on <= data_i[2];
                invert_all     <= data_i[0];
            end
        end
    end

    // ==========================================
    // Wide-line flag
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wide_line_mode <= 1'b0;
        end else if (cmd_wr && is_ext_func && ext_select) begin
            wide_line_mode <= data_i[0];
        end
    end

    // ==========================================
    // Scroll quantity, stored as written; range is flagged, not clipped
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scroll_amount <= 6'h00;
        end else if (cmd_wr && is_addr_cmd && ext_select) begin
            scroll_amount <= data_i[5:0];
        end
    end

    // ==========================================
    // Cursor and display shift pulse
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shift_o <= '0;
        end else begin
            shift_o.valid   <= cmd_wr && data_i[7:4] == 4'h1 && !cfg.ext_select && !cfg.alt_table_select;
            shift_o.display <= data_i[3];
            shift_o.right   <= data_i[2];
        end
    end

    // ==========================================
    // Address counter and RAM target
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_counter <= 7'h00;
            cgram_target <= 1'b0;
        end else if (cmd_wr && data_i[7:6] == 2'h1 && !cfg.ext_select && !cfg.alt_table_select) begin
            addr_counter <= {1'b0, data_i[5:0]};
            cgram_target <= 1'b1;
        end else if (cmd_wr && data_i[7] && !cfg.ext_select) begin
            addr_counter <= data_i[6:0];
            cgram_target <= 1'b0;
        end else if (data_acc) begin
            // CGRAM wraps inside its six address bits
            addr_counter <= cgram_target ? {1'b0, next_addr[5:0]} : next_addr;
        end
    end

    // ==========================================
    // RAM storage, no reset on contents
    always_ff @(posedge sys_clk_i) begin
        if (wr_i && dc_i && fund_tbl) begin
            if (cgram_target) begin
                cgram[addr_counter[5:0]] <= data_i;
            end else begin
                ddram[addr_counter] <= data_i;
            end
        end
    end

    // ==========================================
    // Busy flag: internal operation after every write
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_cnt  <= 3'h0;
            busy_flag <= 1'b0;
        end else if (wr_i && fund_tbl) begin
            busy_cnt  <= 3'(`OCD_BUSY_CYC);
            busy_flag <= 1'b1;
        end else if (busy_cnt != 3'h0) begin
            busy_cnt  <= busy_cnt - 3'h1;
            busy_flag <= busy_cnt != 3'h1;
        end
    end

    // ==========================================
    // Read data path
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            data_o        <= 8'h00;
            status_second <= 1'b0;
        end else if (rd_i && !dc_i && fund_tbl) begin
            data_o        <= {busy_flag, status_second ? `OCD_PART_ID : addr_counter};
            status_second <= !status_second;
        end else if (rd_i && dc_i && fund_tbl) begin
            data_o <= cgram_target ? cgram[addr_counter[5:0]] : ddram[addr_counter];
        end else if (wr_i) begin
            status_second <= 1'b0;
        end
    end

    // ==========================================
    // Registered mirrors
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_o            <= '0;
            addr_counter_o   <= 7'h00;
            cgram_target_o   <= 1'b0;
            scroll_invalid_o <= 1'b0;
        end else begin
            cfg_o            <= cfg;
            addr_counter_o   <= addr_counter;
            cgram_target_o   <= cgram_target;
            scroll_invalid_o <= cfg.scroll_amount > `OCD_SCROLL_MAX;
        end
    end

endmodule : ocd_decoder

// >>> inc/ocd_params.svh
// Constants for the character OLED fundamental command decoder
`ifndef OCD_PARAMS_SVH
`define OCD_PARAMS_SVH

// ==========================================
// Reset values, scroll limit and part ID
`define OCD_HEIGHT_FMT_RST   2'h3
`define OCD_LINE_EN_RST      4'hF
`define OCD_SCROLL_MAX       6'h30
`define OCD_PART_ID          7'h21

// ==========================================
// RAM sizes and timing
`define OCD_DDRAM_WORDS      128
`define OCD_CGRAM_WORDS      64
`define OCD_BUSY_NS          80
`define OCD_CLK_NS           40
`define OCD_BUSY_CYC         ((`OCD_BUSY_NS + `OCD_CLK_NS - 1) / `OCD_CLK_NS)

`endif

// >>> inc/ocd_pkg.sv
// Types for the character OLED fundamental command decoder
package ocd_pkg;

    // ==========================================
    // Mode and configuration carrier
    typedef struct packed {
        logic       alt_table_select;
        logic       ext_select;
        logic       oled_set_select;
        logic [1:0] height_format;
        logic       shift_vs_scroll_mode;
        logic [3:0] line_shift_enable;
        logic [3:0] line_scroll_enable;
        logic       line_count_sel;
        logic       wide_line_mode;
        logic       double_height_two_line;
        logic       cgram_blink_on;
        logic       invert_all;
        logic [5:0] scroll_amount;
    } ocd_cfg_s;

    typedef struct packed {
        logic valid;
        logic display;
        logic right;
    } ocd_shift_s;

endpackage : ocd_pkg

// >>> verif/ocd_host_model.sv
// Host side model: byte transfers, each write followed by a fixed three-cycle wait instead of a busy poll
`timescale 1ns/1ps
module ocd_host_model (
    input  wire logic       clk_i,
    output logic            wr_o,
    output logic            rd_o,
    output logic            dc_o,
    output logic [7:0]      data_o,
    input  wire logic [7:0] rdata_i
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        dc_o = 1'b0;
        data_o = 8'h00;
    end
    // ==========================================
    // Transfers
    task automatic put(input logic dc, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        dc_o <= dc;
        data_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        data_o <= ~d;
        repeat (3) @(posedge clk_i);
    endtask : put
    task automatic get(input logic dc, output logic [7:0] v);
        @(posedge clk_i);
        rd_o <= 1'b1;
        dc_o <= dc;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 v = rdata_i;
    endtask : get
endmodule : ocd_host_model

// >>> verif/ocd_decoder_asserts.sv
// Port level checks of the decoder
`timescale 1ns/1ps
module ocd_decoder_asserts (
    input wire logic                sys_clk_i,
    input wire logic                resetn_i,
    input wire logic                wr_i,
    input wire logic                rd_i,
    input wire logic                dc_i,
    input wire logic [7:0]          data_i,
    input wire logic                entry_incr_i,
    input wire logic [7:0]          data_o,
    input wire ocd_pkg::ocd_cfg_s   cfg_o,
    input wire ocd_pkg::ocd_shift_s shift_o,
    input wire logic [6:0]          addr_counter_o,
    input wire logic                cgram_target_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    wire logic cmd = wr_i & ~dc_i;
    shift_pulse_a: assert property (cmd && data_i[7:4] == 4'h1 && !cfg_o.ext_select && !cfg_o.alt_table_select
        |=> shift_o.valid && shift_o.right == $past(data_i[2])) else $error("shift pulse wrong");
    shift_cause_a: assert property (shift_o.valid |-> $past(cmd) && $past(data_i[7:4]) == 4'h1)
        else $error("shift pulse without command");
    ddram_addr_a: assert property (cmd && data_i[7] && !cfg_o.ext_select
        |-> ##2 addr_counter_o == $past(data_i[6:0], 2) && !cgram_target_o) else $error("ddram address wrong");
    cgram_addr_a: assert property (cmd && data_i[7:6] == 2'h1 && !cfg_o.ext_select && !cfg_o.alt_table_select
        |-> ##2 addr_counter_o == {1'b0, $past(data_i[5:0], 2)} && cgram_target_o) else $error("cgram address wrong");
    func_set_a: assert property (cmd && data_i[7:5] == 3'h1
        |-> ##2 cfg_o.ext_select == $past(data_i[1], 2)) else $error("function set wrong");
    scroll_amt_a: assert property (cmd && data_i[7] && cfg_o.ext_select
        |-> ##2 cfg_o.scroll_amount == $past(data_i[5:0], 2)) else $error("scroll amount wrong");
    ram_step_a: assert property ((wr_i || rd_i) && dc_i && entry_incr_i && !cgram_target_o
        |-> ##2 addr_counter_o == $past(addr_counter_o, 2) + 7'h01) else $error("counter step wrong");
    status_ready_a: assert property (rd_i && !dc_i && !$past(wr_i) && !$past(wr_i, 2) && !$past(wr_i, 3) |=> !data_o[7])
        else $error("busy flag stuck");
    read_hold_a: assert property (!rd_i |=> $stable(data_o)) else $error("read data moved");
endmodule : ocd_decoder_asserts
bind ocd_decoder ocd_decoder_asserts chk_i (.sys_clk_i, .resetn_i, .wr_i, .rd_i, .dc_i, .data_i, .entry_incr_i,
    .data_o, .cfg_o, .shift_o, .addr_counter_o, .cgram_target_o);

// >>> verif/ocd_decoder_tb.sv
// Directed tests of the decoder through the host model
`timescale 1ns/1ps
`include "ocd_params.svh"
module ocd_decoder_tb;
    logic                sys_clk_i = 1'b0;
    logic                resetn_i = 1'b0;
    logic                entry_incr_i = 1'b1;
    logic                wr, rd, dc, cg, sinv;
    logic [7:0]          wd, rdat, v;
    logic [6:0]          ac;
    ocd_pkg::ocd_cfg_s   cfg;
    ocd_pkg::ocd_shift_s sh;
    logic [7:0]          sh_seen = 8'h00;
    int                  errors = 0;
    int                  cmp_count = 0;
    always #20 sys_clk_i = ~sys_clk_i;
    // Shift pulse lasts one cycle, so latch it for later compare
    always @(posedge sys_clk_i) begin
        if (sh.valid) begin
            sh_seen <= {5'h00, 1'b1, sh.display, sh.right};
        end
    end
    ocd_decoder dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .wr_i(wr), .rd_i(rd), .dc_i(dc), .data_i(wd),
        .entry_incr_i(entry_incr_i), .data_o(rdat), .cfg_o(cfg), .shift_o(sh), .addr_counter_o(ac),
        .cgram_target_o(cg), .scroll_invalid_o(sinv));
    ocd_host_model host (.clk_i(sys_clk_i), .wr_o(wr), .rd_o(rd), .dc_o(dc), .data_o(wd), .rdata_i(rdat));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    // Hang guard
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        errors++;
        conclude();
    end
    // ==========================================
    // Tests
    initial begin
        repeat (5) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk("height fmt", 8'h03, {6'h00, cfg.height_format});
        chk("shift en", 8'h0F, {4'h0, cfg.line_shift_enable});
        chk("addr", 8'h00, {1'b0, ac});
        $display("reset test done");
        host.put(1'b0, 8'h85);
        host.put(1'b1, 8'hA5);
        host.put(1'b1, 8'h3C);
        chk("ac inc", 8'h07, {1'b0, ac});
        host.put(1'b0, 8'h85);
        host.get(1'b1, v);
        chk("ddram rd", 8'hA5, v);
        host.get(1'b0, v);
        chk("status ac", 8'h06, v);
        host.get(1'b0, v);
        chk("part id", {1'b0, `OCD_PART_ID}, v);
        @(posedge sys_clk_i) entry_incr_i <= 1'b0;
        host.put(1'b1, 8'h11);
        chk("ac dec", 8'h05, {1'b0, ac});
        $display("ddram test done");
        host.put(1'b0, 8'h4A);
        chk("cg target", 8'h01, {7'h00, cg});
        host.put(1'b1, 8'h1F);
        host.put(1'b0, 8'h4A);
        host.get(1'b1, v);
        chk("cgram rd", 8'h1F, v);
        host.put(1'b0, 8'h2F);
        chk("ext flags", 8'h0F, {4'h0, cfg.line_count_sel, cfg.ext_select, cfg.cgram_blink_on, cfg.invert_all});
        host.put(1'b0, 8'h15);
        chk("height mode", 8'h03, {5'h00, cfg.height_format, cfg.shift_vs_scroll_mode});
        host.put(1'b0, 8'hB1);
        chk("scroll", 8'h31, {2'h0, cfg.scroll_amount});
        chk("scroll bad", 8'h01, {7'h00, sinv});
        chk("ac kept", 8'h09, {1'b0, ac});
        host.put(1'b0, 8'h21);
        host.put(1'b0, 8'h2A);
        host.put(1'b0, 8'h1A);
        chk("line shift", 8'h0A, {4'h0, cfg.line_shift_enable});
        chk("line scroll", 8'h0F, {4'h0, cfg.line_scroll_enable});
        host.put(1'b0, 8'h20);
        host.put(1'b0, 8'h1C);
        chk("alt sel", 8'h00, {7'h00, cfg.alt_table_select});
        chk("shift", 8'h07, sh_seen);
        host.put(1'b0, 8'h24);
        chk("dbl height", 8'h01, {7'h00, cfg.double_height_two_line});
        chk("line count", 8'h00, {7'h00, cfg.line_count_sel});
        host.put(1'b0, 8'h2A);
        host.put(1'b0, 8'h09);
        chk("wide line", 8'h01, {7'h00, cfg.wide_line_mode});
        $display("ext test done");
        conclude();
    end
endmodule : ocd_decoder_tb
